/* File: verilog/epi_top.sv */
// Top of the external pin interrupt unit with APB register slave.
// Assumes APB master on MCLK; the core acks vectors with a pulse.
`timescale 1ns/1ns
`default_nettype none
`include "epi_consts.svh"
module epi_top (
  input wire logic MCLK, // 50 MHz clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic [11:0] PADDR, // APB address
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic LINE0_PIN, // Line-0 pin level
  input wire logic LINE1_PIN, // Line-1 pin level
  input wire logic VEC_ACK, // Core takes the presented vector
  output logic CORE_REQ, // Interrupt request to core
  output logic [3:0] CORE_VEC, // Vector of highest request
  output logic WAKE_REQ, // Low-level wake request, clockless
  output logic SLEEP_ENABLE, // Sleep enable control bit
  output logic [2:0] SLEEP_MODE, // Sleep mode field
  output logic IRQ // Status interrupt output
);
  // ****************************************
  // Registers and bus decode
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] enable_q;
  logic global_q;
  logic [1:0] flag_q;
  logic [1:0] status_q;
  logic [1:0] irq_en_q;
  logic [1:0] vec_q;
  logic [3:0] vec_out_q;
  logic [31:0] rdata_q;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [1:0] ev;
  logic [1:0] low;
  logic [1:0] level_mode;
  logic [1:0] flag_w1c;
  logic [1:0] st_w1c;
  logic [1:0] take;
  logic [1:0] pend;
  logic [1:0] en_pair;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `EPI_OFF_CTRL) || (a == `EPI_OFF_ENABLE) ||
      (a == `EPI_OFF_FLAGS) || (a == `EPI_OFF_STATUS) ||
      (a == `EPI_OFF_CLEAR) || (a == `EPI_OFF_IRQ_EN) ||
      (a == `EPI_OFF_GLOBAL);
  endfunction

  function automatic logic [1:0] pick(input logic [7:0] d);
    pick = {d[`EPI_BIT_LINE1], d[`EPI_BIT_LINE0]};
  endfunction

  assign hit = mapped(PADDR);
  assign wr_en = PSEL && PENABLE && PWRITE && hit;
  // Read data loads in setup, so PRDATA is settled by the access phase
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // ****************************************
  // Line detectors
  // ****************************************
  epi_line_detect u_line0 (
    .clk(MCLK),
    .rst_n(RST_N),
    .pin(LINE0_PIN),
    .sense(ctrl_q[`EPI_L0_SENSE_HI:`EPI_L0_SENSE_LO]),
    .event_o(ev[0]),
    .low_async(low[0])
  );
  epi_line_detect u_line1 (
    .clk(MCLK),
    .rst_n(RST_N),
    .pin(LINE1_PIN),
    .sense(ctrl_q[`EPI_L1_SENSE_HI:`EPI_L1_SENSE_LO]),
    .event_o(ev[1]),
    .low_async(low[1])
  );

  // Level lines skip the flag; the pin itself is the request
  assign level_mode[0] = ctrl_q[`EPI_L0_SENSE_HI:`EPI_L0_SENSE_LO] == 2'b00;
  assign level_mode[1] = ctrl_q[`EPI_L1_SENSE_HI:`EPI_L1_SENSE_LO] == 2'b00;

  // ****************************************
  // Control, enable, global
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_q <= `EPI_CTRL_RESET;
    end else if (wr_en && PADDR == `EPI_OFF_CTRL) begin
      ctrl_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      enable_q <= `EPI_ENABLE_RESET;
      global_q <= 1'b0;
      irq_en_q <= 2'b00;
    end else if (wr_en) begin
      if (PADDR == `EPI_OFF_ENABLE) begin
        enable_q <= PWDATA[7:0];
      end
      if (PADDR == `EPI_OFF_GLOBAL) begin
        global_q <= PWDATA[0];
      end
      if (PADDR == `EPI_OFF_IRQ_EN) begin
        irq_en_q <= pick(PWDATA[7:0]);
      end
    end
  end

  assign SLEEP_ENABLE = ctrl_q[`EPI_BIT_SLEEP_EN];
  assign SLEEP_MODE = ctrl_q[`EPI_SLEEP_MODE_HI:`EPI_SLEEP_MODE_LO];

  // ****************************************
  // Flags
  // ****************************************
  assign flag_w1c = (wr_en && PADDR == `EPI_OFF_FLAGS) ? pick(PWDATA[7:0]) : 2'b00;
  // Ack clears the line whose vector was on show, one cycle behind pend
  assign take = VEC_ACK ? vec_q : 2'b00;

  // Set wins over any clear arriving in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flag_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (level_mode[i]) begin
          flag_q[i] <= 1'b0;
        end else if (ev[i]) begin
          flag_q[i] <= 1'b1;
        end else if (flag_w1c[i] || take[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Core request and vectors
  // ****************************************
  assign en_pair = pick(enable_q);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pend[i] = (level_mode[i] ? low[i] : flag_q[i]) && en_pair[i]
        && global_q;
    end
  end

  assign CORE_REQ = |pend;
  assign WAKE_REQ = global_q && |(low & level_mode & en_pair);

  // Line 0 has the lower vector, so it wins when both pend
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      vec_q <= 2'b00;
      vec_out_q <= `EPI_VEC_NONE;
    end else if (pend[0]) begin
      vec_q <= 2'b01;
      vec_out_q <= `EPI_VEC_LINE0;
    end else if (pend[1]) begin
      vec_q <= 2'b10;
      vec_out_q <= `EPI_VEC_LINE1;
    end else begin
      vec_q <= 2'b00;
      vec_out_q <= `EPI_VEC_NONE;
    end
  end
  assign CORE_VEC = vec_out_q;

  // ****************************************
  // Status interrupt
  // ****************************************
  assign st_w1c = (wr_en && PADDR == `EPI_OFF_CLEAR) ? pick(PWDATA[7:0]) : 2'b00;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      status_q <= 2'b00;
    end else begin
      status_q <= (status_q & ~st_w1c) | ev;
    end
  end

  assign IRQ = |(status_q & irq_en_q);

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (PADDR)
        `EPI_OFF_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
        `EPI_OFF_ENABLE: rdata_q <= {24'h00_0000, enable_q[7:6], 6'h00};
        `EPI_OFF_FLAGS: rdata_q <= {24'h00_0000, flag_q & ~level_mode, 6'h00};
        `EPI_OFF_STATUS: rdata_q <= {24'h00_0000, status_q, 6'h00};
        `EPI_OFF_IRQ_EN: rdata_q <= {24'h00_0000, irq_en_q, 6'h00};
        `EPI_OFF_GLOBAL: rdata_q <= {31'h0000_0000, global_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign PRDATA = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence fall_seen(int i);
    ##0 ev[i] && !level_mode[i];
  endsequence

  // Clear paths only count when no event competes in that cycle
  sequence w1c_alone(int i);
    flag_w1c[i] && !ev[i];
  endsequence
  sequence ack_alone(int i);
    take[i] && !ev[i];
  endsequence

  flag_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    fall_seen(0) |=> flag_q[0])
    else $error("line0 flag not set by event");
  flag_set1_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    fall_seen(1) |=> flag_q[1])
    else $error("line1 flag not set by event");
  level_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(level_mode[0]) |-> !flag_q[0])
    else $error("level line flag not zero");
  w1c_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    flag_w1c[1] && !ev[1] |=> !flag_q[1])
    else $error("write one did not clear flag");
  w0_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && PADDR == `EPI_OFF_FLAGS && !PWDATA[6] && flag_q[0] && !level_mode[0]
      && !take[0] |=> flag_q[0])
    else $error("write zero changed flag");
  gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CORE_REQ |-> global_q && (enable_q[7] || enable_q[6]))
    else $error("request without enables");
  level_req_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    level_mode[1] && !LINE1_PIN && enable_q[7] && global_q |-> CORE_REQ)
    else $error("level request dropped");
  vec_pick_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    pend[1] && !pend[0] |=> CORE_VEC == `EPI_VEC_LINE1)
    else $error("wrong vector for line1");
  ack_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    take[0] && !ev[0] |=> !flag_q[0])
    else $error("vector ack did not clear flag");
  ctrl_wr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && PADDR == `EPI_OFF_CTRL |=> ctrl_q == $past(PWDATA[7:0]))
    else $error("control write lost");

  // ****************************************
  // Checks of the other line, bus and status
  // ****************************************
  level_clear1_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(level_mode[1]) |-> !flag_q[1])
    else $error("level line1 flag not zero");
  w1c_clear0_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    w1c_alone(0) |=> !flag_q[0])
    else $error("write one did not clear line0 flag");
  w0_keep1_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && PADDR == `EPI_OFF_FLAGS && !PWDATA[7] && flag_q[1] && !level_mode[1]
      && !take[1] |=> flag_q[1])
    else $error("write zero changed line1 flag");
  ack_clear1_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ack_alone(1) |=> !flag_q[1])
    else $error("vector ack did not clear line1 flag");
  vec_pick0_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    pend[0] |=> CORE_VEC == `EPI_VEC_LINE0)
    else $error("wrong vector for line0");
  vec_none_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !pend[0] && !pend[1] |=> CORE_VEC == `EPI_VEC_NONE)
    else $error("vector shown with nothing pending");
  level_req0_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    level_mode[0] && !LINE0_PIN && enable_q[6] && global_q |-> CORE_REQ)
    else $error("line0 level request dropped");
  global_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !global_q |-> !CORE_REQ && !WAKE_REQ)
    else $error("request with global enable off");
  enable_wr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_en && PADDR == `EPI_OFF_ENABLE |=> enable_q[7:6] == $past(PWDATA[7:6]))
    else $error("enable write lost");
  flag_layout_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_en && PADDR == `EPI_OFF_FLAGS |=> PRDATA[31:8] == 24'h00_0000
      && PRDATA[5:0] == 6'h00)
    else $error("flag register layout wrong");
  flag_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_en && PADDR == `EPI_OFF_FLAGS && level_mode[0] |=> !PRDATA[6])
    else $error("level line0 flag read as one");
  status_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ev[0] |=> status_q[0])
    else $error("line0 status not set by event");
  status_clr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_w1c[1] && !ev[1] |=> !status_q[1])
    else $error("line1 status not cleared");
  irq_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    irq_en_q == 2'b00 |-> !IRQ)
    else $error("status interrupt with no enable");
  bad_addr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    PSEL && PENABLE && PWRITE && !hit |=> $stable(ctrl_q) && $stable(enable_q))
    else $error("unmapped write changed a register");
endmodule // epi_top
`default_nettype wire

/* File: verilog/epi_consts.svh */
// Constants of the external pin interrupt unit: offsets, fields, resets.
// Assumes inclusion by bare name from the unit's design files.
// Overview of operation
// - Line-1 sense bits 3:2 pick the trigger
// - Line-0 sense bits 1:0 pick the trigger
// - Pins sampled first; pulses over one clock caught
// - Request delivered only with line and global enable
// - Pin activity counts even when pin drives out
// - Qualifying event sets the line's flag
// - Taking the vector clears the line's flag
// - Writing one clears a flag; zero leaves it
// - Level-mode line's flag always reads zero
// - Each line has its own vector
// - Control: sleep enable, sleep mode, sense fields
// - Enable register: line1 bit 7, line0 bit 6
// - Flag register: line1 bit 7, line0 bit 6
// - Edges need clock; low level detected without it
// - Enabled level line requests while pin stays low
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define EPI_OFF_CTRL 12'h000
`define EPI_OFF_ENABLE 12'h004
`define EPI_OFF_FLAGS 12'h008
`define EPI_OFF_STATUS 12'h00c
`define EPI_OFF_CLEAR 12'h010
`define EPI_OFF_IRQ_EN 12'h014
`define EPI_OFF_GLOBAL 12'h018
// ****************************************
// Field positions
// ****************************************
`define EPI_BIT_SLEEP_EN 7
`define EPI_SLEEP_MODE_HI 6
`define EPI_SLEEP_MODE_LO 4
`define EPI_L1_SENSE_HI 3
`define EPI_L1_SENSE_LO 2
`define EPI_L0_SENSE_HI 1
`define EPI_L0_SENSE_LO 0
`define EPI_BIT_LINE1 7
`define EPI_BIT_LINE0 6
// ****************************************
// Reset values and vector codes
// ****************************************
`define EPI_CTRL_RESET 8'h00
`define EPI_ENABLE_RESET 8'h00
`define EPI_VEC_LINE0 4'h1
`define EPI_VEC_LINE1 4'h2
`define EPI_VEC_NONE 4'h0

`endif

/* File: verilog/epi_pkg.sv */
// Types shared by the external pin interrupt unit.
// Assumes nothing of its surroundings.
package epi_pkg;
  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_e;
endpackage

/* File: verilog/epi_line_detect.sv */
// One pin line: synchroniser, edge detector and level path.
// Assumes one clock; the pin may change at any time.
`timescale 1ns/1ns
`default_nettype none
module epi_line_detect (
  input wire logic clk, // Module clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic pin, // Raw pin level
  input wire logic [1:0] sense, // Sense selection
  output logic event_o, // One-cycle edge event
  output logic low_async // Raw low level, no clock needed
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  epi_pkg::epi_sense_e mode;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_comb begin
    mode = epi_pkg::epi_sense_e'(sense);
    case (mode)
      epi_pkg::EPI_SENSE_ANY: event_o = sync2_q ^ prev_q;
      epi_pkg::EPI_SENSE_FALL: event_o = prev_q & ~sync2_q;
      epi_pkg::EPI_SENSE_RISE: event_o = ~prev_q & sync2_q;
      default: event_o = 1'b0;
    endcase
  end

  // Level path bypasses the clock so it can wake a stopped core
  assign low_async = ~pin;

  edge_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    event_o |=> !event_o || (sync2_q != $past(sync2_q)))
    else $error("edge event repeated without pin change");
endmodule // epi_line_detect
`default_nettype wire

/* File: testbench/epi_pin_src.sv */
// Pin source model driving both interrupt pin lines.
// Assumes the bench calls drive() and runs one clock into clk.
`timescale 1ns/1ns
`default_nettype none
module epi_pin_src (
  input wire logic clk, // Bench clock
  output var logic LINE0_PIN, // Line-0 pin level
  output var logic LINE1_PIN // Line-1 pin level
);
  initial begin
    LINE0_PIN = 1'b1;
    LINE1_PIN = 1'b1;
  end
  // Levels change only after an edge and hold for whole cycles
  task automatic drive(input logic l, input logic v);
    @(posedge clk);
    if (l)
      LINE1_PIN <= v;
    else
      LINE0_PIN <= v;
  endtask
endmodule // epi_pin_src
`default_nettype wire

/* File: testbench/epi_top_bench.sv */
// Self-checking bench of the pin interrupt unit over APB.
// Assumes epi_top, epi_pin_src and the constants header.
`timescale 1ns/1ns
`default_nettype none
`include "epi_consts.svh"
module epi_top_bench;
  logic MCLK = 1'b0, RST_N = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ack = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, err, l0, l1, CORE_REQ, WAKE_REQ, SLEEP_ENABLE, IRQ;
  logic [3:0] CORE_VEC;
  logic [2:0] SLEEP_MODE;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #10 MCLK = ~MCLK;
  epi_pin_src src (.clk(MCLK), .LINE0_PIN(l0), .LINE1_PIN(l1));
  epi_top DUT (.MCLK(MCLK), .RST_N(RST_N), .PADDR(pa), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PWDATA(pwd), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LINE0_PIN(l0), .LINE1_PIN(l1), .VEC_ACK(ack), .CORE_REQ(CORE_REQ),
    .CORE_VEC(CORE_VEC), .WAKE_REQ(WAKE_REQ), .SLEEP_ENABLE(SLEEP_ENABLE),
    .SLEEP_MODE(SLEEP_MODE), .IRQ(IRQ));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    // Whole run needs a few hundred cycles
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge MCLK);
    pen <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    apb(0, `EPI_OFF_CTRL, 0);
    chk(rd, 32'h0);
    apb(0, `EPI_OFF_ENABLE, 0);
    chk(rd, 32'h0);
    apb(0, 12'h020, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1, `EPI_OFF_CTRL, 32'hff);
    apb(0, `EPI_OFF_CTRL, 0);
    chk(rd, 32'hff);
    chk({SLEEP_ENABLE, SLEEP_MODE}, 4'hf);
    apb(1, `EPI_OFF_CTRL, 32'h0);
    $display("test regs done");
  endtask
  // Every sense code on both lines, falling then rising edge
  task automatic t_modes();
    logic [31:0] b;
    for (int ln = 0; ln < 2; ln++) begin
      for (int m = 0; m < 4; m++) begin
        b = 32'h40 << ln;
        apb(1, `EPI_OFF_CTRL, m << (2 * ln));
        apb(1, `EPI_OFF_FLAGS, 32'hc0);
        src.drive(ln[0], 1'b0);
        wt(6);
        apb(0, `EPI_OFF_FLAGS, 0);
        chk(rd, (m == 1 || m == 2) ? b : 32'h0);
        apb(1, `EPI_OFF_FLAGS, 32'h0);
        apb(0, `EPI_OFF_FLAGS, 0);
        chk(rd, (m == 1 || m == 2) ? b : 32'h0);
        apb(1, `EPI_OFF_FLAGS, 32'hc0);
        src.drive(ln[0], 1'b1);
        wt(6);
        apb(0, `EPI_OFF_FLAGS, 0);
        chk(rd, (m == 1 || m == 3) ? b : 32'h0);
        apb(1, `EPI_OFF_FLAGS, b);
        apb(0, `EPI_OFF_FLAGS, 0);
        chk(rd, 32'h0);
      end
    end
    $display("test modes done");
  endtask
  task automatic t_vector();
    apb(1, `EPI_OFF_CTRL, 32'h08);
    apb(1, `EPI_OFF_ENABLE, 32'h80);
    apb(1, `EPI_OFF_GLOBAL, 32'h0);
    apb(1, `EPI_OFF_FLAGS, 32'hc0);
    src.drive(1'b1, 1'b0);
    wt(6);
    chk({31'h0, CORE_REQ}, 32'h0);
    apb(1, `EPI_OFF_GLOBAL, 32'h1);
    wt(2);
    chk({CORE_REQ, CORE_VEC}, {1'b1, `EPI_VEC_LINE1});
    @(posedge MCLK);
    ack <= 1'b1;
    @(posedge MCLK);
    ack <= 1'b0;
    wt(2);
    apb(0, `EPI_OFF_FLAGS, 0);
    chk(rd, 32'h0);
    chk({31'h0, CORE_REQ}, 32'h0);
    src.drive(1'b1, 1'b1);
    $display("test vector done");
  endtask
  // Source holds line-0 low across one register read
  task automatic t_level();
    apb(1, `EPI_OFF_CTRL, 32'h0);
    apb(1, `EPI_OFF_ENABLE, 32'h40);
    src.drive(1'b0, 1'b0);
    wt(6);
    chk({CORE_REQ, WAKE_REQ}, 2'b11);
    chk(CORE_VEC, `EPI_VEC_LINE0);
    apb(0, `EPI_OFF_FLAGS, 0);
    chk(rd, 32'h0);
    chk({CORE_REQ, WAKE_REQ}, 2'b11);
    src.drive(1'b0, 1'b1);
    wt(2);
    chk({CORE_REQ, WAKE_REQ}, 2'b00);
    $display("test level done");
  endtask
  task automatic t_irq();
    apb(1, `EPI_OFF_CLEAR, 32'hc0);
    apb(0, `EPI_OFF_STATUS, 0);
    chk(rd, 32'h0);
    apb(1, `EPI_OFF_IRQ_EN, 32'h40);
    apb(1, `EPI_OFF_CTRL, 32'h03);
    src.drive(1'b0, 1'b0);
    src.drive(1'b0, 1'b1);
    wt(6);
    apb(0, `EPI_OFF_STATUS, 0);
    chk(rd, 32'h40);
    chk({31'h0, IRQ}, 32'h1);
    apb(1, `EPI_OFF_IRQ_EN, 32'h80);
    wt(1);
    chk({31'h0, IRQ}, 32'h0);
    apb(1, `EPI_OFF_IRQ_EN, 32'h40);
    apb(1, `EPI_OFF_CLEAR, 32'h40);
    apb(0, `EPI_OFF_STATUS, 0);
    chk({rd[30:0], IRQ}, 32'h0);
    $display("test irq done");
  endtask
  initial begin
    wt(8);
    RST_N <= 1'b1;
    t_regs();
    t_modes();
    t_vector();
    t_level();
    t_irq();
    end_sim();
  end
endmodule // epi_top_bench
`default_nettype wire
